// [rtl/prc_params.svh]
// Constants for the pulse rate trigger and up/down counter
`ifndef PRC_PARAMS_SVH
`define PRC_PARAMS_SVH

// -----------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------
`define PRC_CLK_HZ 20000000
`define PRC_TICK_MS 10
`define PRC_TICK_CYCLES (`PRC_CLK_HZ / 1000 * `PRC_TICK_MS)

// -----------------------------------------------------------------------
// Setting ranges
// -----------------------------------------------------------------------
`define PRC_ON_MAX 32'h05f5e0ff
`define PRC_OFF_MAX 32'h3b9ac9ff
`define PRC_PRESET_MAX 32'h05f5e0ff
`define PRC_GATE_MIN 32'h00000001
`define PRC_GATE_MAX 32'h157529ff
`define PRC_COUNT_MAX 32'hffffffff

// -----------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------
`define PRC_RST_VALUE 32'h00000000
`define PRC_RST_TICKS 29'h00000000
`define PRC_RST_FLAG 1'b0

`endif

// [rtl/prc_pkg.sv]
// Types and helper functions for the pulse rate trigger and counter
`default_nettype none
`include "prc_params.svh"

package prc_pkg;

   // --------------------------------------------------------------------
   // Configuration carrier of the rate trigger
   // --------------------------------------------------------------------
   typedef struct packed {
      logic falling;            // 1: count falling edges
      logic [26:0] on_thr;      // On threshold
      logic [29:0] off_thr;     // Off threshold
      logic [28:0] gate_ticks;  // Gate time in 10 ms units
   } prc_rtt_cfg_type;

   // --------------------------------------------------------------------
   // Gate state machine
   // --------------------------------------------------------------------
   typedef enum logic [1:0] {
      PRC_IDLE = 2'b01,
      PRC_GATE = 2'b10
   } prc_gate_state_type;

   // --------------------------------------------------------------------
   // Functions
   // --------------------------------------------------------------------
   // Limit a setting to its legal range
   function automatic logic [31:0] prc_clamp(input logic [31:0] v,
                                             input logic [31:0] lo,
                                             input logic [31:0] hi);
      logic [31:0] r;
      r = v;
      if (v < lo) r = lo;
      if (v > hi) r = hi;
      return r;
   endfunction : prc_clamp

   // Increment that sticks at the top instead of wrapping
   function automatic logic [31:0] prc_sat_inc(input logic [31:0] v);
      logic [31:0] r;
      r = (v == `PRC_COUNT_MAX) ? v : v + 32'h00000001;
      return r;
   endfunction : prc_sat_inc

endpackage : prc_pkg
`default_nettype wire

// [rtl/prc_edge_sync.sv]
// Two-stage synchroniser with rise and fall pulse detection
`timescale 1ns/1ps
`default_nettype none

module prc_edge_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin,
   output logic rise,
   output logic fall
);

   logic meta_q;
   logic sync_q;
   logic prev_q;

   // -----------------------------------------------------------------
   // Synchroniser and history
   // -----------------------------------------------------------------
   // Only sync_q reads meta_q
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= pin;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // One-cycle edge pulses
   assign rise = sync_q & ~prev_q;
   assign fall = ~sync_q & prev_q;

endmodule : prc_edge_sync

`default_nettype wire

// [rtl/prc_top.sv]
// Pulse rate threshold trigger and up/down pulse counter
// Behaviour
// RQ1: Arm input edge of either sense starts measurement
// RQ2: Rising mode counts only low-to-high pulse edges
// RQ3: Falling mode counts only high-to-low pulse edges
// RQ4: Trigger clear zeroes count, output; beats pulses
// RQ5: Running values always driven on value outputs
// RQ6: On threshold to 99999999, off to 999999999
// RQ7: Gate time 10 ms to 999:59:59.990
// RQ8: On not below off: hysteresis set/clear
// RQ9: On below off: set inside window
// RQ10: Configurer uses high-speed mode above 4 Hz
// RQ11: At most eight high-speed blocks per program
// RQ12: Up input pulse increments the counter
// RQ13: Down input pulse decrements the counter
// RQ14: Counter counts only rising count input edges
// RQ15: Counter clear zeroes count, output; beats inputs
// RQ16: Counter output set once count reaches preset
// RQ17: Preset accepted from 0 to 99999999
// RQ18: Rate is edges per gate, latched at end
// RQ19: On below off: outside window clears output
`timescale 1ns/1ps
`default_nettype none
`include "prc_params.svh"

module prc_top #(
   parameter int TICK_CYCLES = `PRC_TICK_CYCLES
) (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic RTT_ARM,
   input wire logic PULSE_IN,
   input wire logic RTT_CLEAR,
   input wire prc_pkg::prc_rtt_cfg_type RTT_CFG,
   output logic RTT_Q,
   output logic RTT_BUSY,
   output logic [31:0] RTT_VALUE,
   output logic [31:0] RTT_RATE,
   input wire logic UP_IN,
   input wire logic DOWN_IN,
   input wire logic UDC_CLEAR,
   input wire logic [26:0] UDC_PRESET,
   output logic UDC_Q,
   output logic [31:0] UDC_VALUE
);

   import prc_pkg::*;

   localparam int PW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   logic arm_rise;
   logic arm_fall;
   logic pls_rise;
   logic pls_fall;
   logic up_rise;
   logic dn_rise;
   logic [31:0] on_c;
   logic [31:0] off_c;
   logic [31:0] gate_c;
   logic [31:0] preset_c;
   prc_gate_state_type state_q;
   logic [PW-1:0] presc_q;
   logic [28:0] ticks_q;
   logic [31:0] count_q;
   logic [31:0] rate_q;
   logic rtt_q_q;
   logic [31:0] udc_q;
   logic udc_hit_q;
   logic arm_edge;
   logic tick;
   logic gate_end;
   logic inc;

   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   // Gate arm pin
   prc_edge_sync u_arm (
      .clk(CLOCK),
      .rst_n(RST_N),
      .pin(RTT_ARM),
      .rise(arm_rise),
      .fall(arm_fall)
   );

   // Measured pulse pin
   prc_edge_sync u_pls (
      .clk(CLOCK),
      .rst_n(RST_N),
      .pin(PULSE_IN),
      .rise(pls_rise),
      .fall(pls_fall)
   );

   // Up count pin
   prc_edge_sync u_up (
      .clk(CLOCK),
      .rst_n(RST_N),
      .pin(UP_IN),
      .rise(up_rise),
      .fall()
   );

   // Down count pin, falling edges unused
   prc_edge_sync u_dn (
      .clk(CLOCK),
      .rst_n(RST_N),
      .pin(DOWN_IN),
      .rise(dn_rise),
      .fall()
   );

   // -----------------------------------------------------------------
   // Settings limited to their legal ranges
   // -----------------------------------------------------------------
   assign on_c = prc_clamp({5'h00, RTT_CFG.on_thr}, `PRC_RST_VALUE,
                           `PRC_ON_MAX); // RQ6
   assign off_c = prc_clamp({2'h0, RTT_CFG.off_thr}, `PRC_RST_VALUE,
                            `PRC_OFF_MAX); // RQ6
   assign gate_c = prc_clamp({3'h0, RTT_CFG.gate_ticks}, `PRC_GATE_MIN,
                             `PRC_GATE_MAX); // RQ7
   assign preset_c = prc_clamp({5'h00, UDC_PRESET}, `PRC_RST_VALUE,
                               `PRC_PRESET_MAX); // RQ17

   // -----------------------------------------------------------------
   // Gate control
   // -----------------------------------------------------------------
   // Any arm transition restarts the interval
   assign arm_edge = arm_rise | arm_fall; // RQ1
   assign tick = (state_q == PRC_GATE) &&
                 (presc_q == PW'(TICK_CYCLES - 1));
   assign gate_end = tick && ({3'h0, ticks_q} == gate_c - 32'h00000001);

   // Gate state: clear stops, arm edge starts
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         state_q <= PRC_IDLE;
      end else begin
         case (state_q)
            PRC_IDLE: begin
               if (!RTT_CLEAR && arm_edge) state_q <= PRC_GATE; // RQ1
            end
            PRC_GATE: begin
               if (RTT_CLEAR) state_q <= PRC_IDLE; // RQ4
            end
            default: begin
               state_q <= PRC_IDLE;
            end
         endcase
      end
   end

   // Prescaler for the 10 ms time base
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         presc_q <= '0;
      end else if (RTT_CLEAR || arm_edge || state_q != PRC_GATE) begin
         presc_q <= '0;
      end else if (tick) begin
         presc_q <= '0;
      end else begin
         presc_q <= presc_q + PW'(1);
      end
   end

   // Time base ticks elapsed in the current gate
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         ticks_q <= `PRC_RST_TICKS;
      end else if (RTT_CLEAR || arm_edge || state_q != PRC_GATE) begin
         ticks_q <= `PRC_RST_TICKS;
      end else if (gate_end) begin
         ticks_q <= `PRC_RST_TICKS; // RQ7
      end else if (tick) begin
         ticks_q <= ticks_q + 29'h00000001;
      end
   end

   // -----------------------------------------------------------------
   // Edge counting and rate latch
   // -----------------------------------------------------------------
   // Qualifying edge for the selected sense
   assign inc = (state_q == PRC_GATE) &&
                (RTT_CFG.falling ? pls_fall : pls_rise); // RQ2 RQ3

   // Running edge count, restarted at each gate end
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         count_q <= `PRC_RST_VALUE;
      end else if (RTT_CLEAR) begin
         count_q <= `PRC_RST_VALUE; // RQ4
      end else if (arm_edge || gate_end) begin
         count_q <= `PRC_RST_VALUE; // RQ18
      end else if (inc) begin
         count_q <= prc_sat_inc(count_q); // RQ2 RQ3
      end
   end

   // Measured rate including an edge in the closing cycle
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         rate_q <= `PRC_RST_VALUE;
      end else if (RTT_CLEAR) begin
         rate_q <= `PRC_RST_VALUE; // RQ4
      end else if (gate_end) begin
         rate_q <= inc ? prc_sat_inc(count_q) : count_q; // RQ18
      end
   end

   // Switching output from the measured rate
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         rtt_q_q <= `PRC_RST_FLAG;
      end else if (RTT_CLEAR) begin
         rtt_q_q <= 1'b0; // RQ4
      end else if (on_c >= off_c) begin
         if (rate_q >= on_c) rtt_q_q <= 1'b1; // RQ8
         else if (rate_q < off_c) rtt_q_q <= 1'b0; // RQ8
      end else begin
         rtt_q_q <= (rate_q >= on_c) && (rate_q < off_c); // RQ9 RQ19
      end
   end

   // -----------------------------------------------------------------
   // Up/down counter
   // -----------------------------------------------------------------
   // Opposing edges in one cycle cancel; floor at zero
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         udc_q <= `PRC_RST_VALUE;
      end else if (UDC_CLEAR) begin
         udc_q <= `PRC_RST_VALUE; // RQ15
      end else if (up_rise && !dn_rise) begin
         udc_q <= prc_sat_inc(udc_q); // RQ12 RQ14
      end else if (dn_rise && !up_rise && udc_q != `PRC_RST_VALUE) begin
         udc_q <= udc_q - 32'h00000001; // RQ13 RQ14
      end
   end

   // Compare output against the preset
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         udc_hit_q <= `PRC_RST_FLAG;
      end else if (UDC_CLEAR) begin
         udc_hit_q <= 1'b0; // RQ15
      end else begin
         udc_hit_q <= (udc_q >= preset_c); // RQ16
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign RTT_Q = rtt_q_q;
   assign RTT_BUSY = (state_q == PRC_GATE);
   assign RTT_VALUE = count_q; // RQ5
   assign RTT_RATE = rate_q; // RQ5
   assign UDC_Q = udc_hit_q;
   assign UDC_VALUE = udc_q; // RQ5

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RST_N);

   a_arm_starts_gate: assert property ( // RQ1
      (arm_edge && !RTT_CLEAR) |=> (RTT_BUSY && RTT_VALUE == 32'h0 &&
                                    ticks_q == 29'h0))
      else $error("arm edge did not start a fresh gate");
   a_rise_counted: assert property ( // RQ2
      (RTT_BUSY && !RTT_CFG.falling && pls_rise && !RTT_CLEAR &&
       !arm_edge && !gate_end && count_q != `PRC_COUNT_MAX)
      |=> RTT_VALUE == $past(count_q) + 32'h1)
      else $error("rising edge not counted");
   a_fall_ignores_rise: assert property ( // RQ3
      (RTT_CFG.falling && pls_rise && !RTT_CLEAR && !arm_edge &&
       !gate_end) |=> $stable(RTT_VALUE))
      else $error("rising edge counted in falling mode");

   a_rtt_clear_wins: assert property ( // RQ4
      RTT_CLEAR |=> (RTT_VALUE == 32'h0 && !RTT_Q && RTT_RATE == 32'h0))
      else $error("trigger clear did not zero count and output");
   a_rate_latched: assert property ( // RQ18
      (gate_end && !RTT_CLEAR && !inc) |=>
      (RTT_RATE == $past(count_q) && RTT_VALUE == 32'h0))
      else $error("rate not latched at gate end");

   a_hyst_set: assert property ( // RQ8
      (!RTT_CLEAR && on_c >= off_c && rate_q >= on_c) |=> RTT_Q)
      else $error("output not set at on threshold");
   a_hyst_hold: assert property ( // RQ8
      (!RTT_CLEAR && on_c >= off_c && rate_q < on_c && rate_q >= off_c)
      |=> RTT_Q == $past(RTT_Q))
      else $error("output changed inside hysteresis band");

   a_window_in: assert property ( // RQ9
      (!RTT_CLEAR && on_c < off_c && rate_q >= on_c && rate_q < off_c)
      |=> RTT_Q)
      else $error("output not set inside window");
   a_window_out: assert property ( // RQ19
      (on_c < off_c && (rate_q < on_c || rate_q >= off_c)) |=> !RTT_Q)
      else $error("output set outside window");

   a_up_counts: assert property ( // RQ12
      (up_rise && !dn_rise && !UDC_CLEAR && udc_q != `PRC_COUNT_MAX)
      |=> UDC_VALUE == $past(udc_q) + 32'h1)
      else $error("up pulse not counted");
   a_down_counts: assert property ( // RQ13
      (dn_rise && !up_rise && !UDC_CLEAR && udc_q != 32'h0)
      |=> UDC_VALUE == $past(udc_q) - 32'h1)
      else $error("down pulse not counted");

   a_fall_no_count: assert property ( // RQ14
      (!up_rise && !dn_rise && !UDC_CLEAR) |=> $stable(UDC_VALUE))
      else $error("counter moved without a rising edge");
   a_udc_clear_wins: assert property ( // RQ15
      UDC_CLEAR |=> (UDC_VALUE == 32'h0 && !UDC_Q))
      else $error("counter clear did not win");

   a_preset_hit: assert property ( // RQ16
      (!UDC_CLEAR && udc_q >= preset_c) |=> UDC_Q)
      else $error("output not set at preset");

   c_rtt_on: cover property ($rose(RTT_Q));
   c_gate_end: cover property (gate_end && count_q != 32'h0);
   c_udc_hit: cover property ($rose(UDC_Q));
   c_clear_vs_pulse: cover property (UDC_CLEAR && up_rise && dn_rise);

endmodule : prc_top

`default_nettype wire

// [dv/prc_pin_src.sv]
// Stand-in for an external pulse generator driving one input pin
`timescale 1ns/1ps
`default_nettype none

module prc_pin_src (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic go,
   input wire logic [7:0] n,
   output logic pin,
   output logic busy
);
   logic [7:0] left_q;
   logic hold_q;

   // Toggle the pin n times, each level held two clocks
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin <= 1'b0;
         busy <= 1'b0;
         left_q <= 8'h00;
         hold_q <= 1'b0;
      end else if (go && !busy) begin
         left_q <= n;
         busy <= (n != 8'h00);
         hold_q <= 1'b0;
      end else if (busy) begin
         hold_q <= ~hold_q;
         if (hold_q) begin
            pin <= ~pin;
            left_q <= left_q - 8'h01;
            busy <= (left_q != 8'h01);
         end
      end
   end
endmodule : prc_pin_src
`default_nettype wire

// [dv/test_prc_top.sv]
// Self-checking bench for the rate trigger and up/down counter
`timescale 1ns/1ps
`default_nettype none

module test_prc_top;
   import prc_pkg::*;
   localparam int TICK = 4;
   localparam int GT = 50;
   localparam int P = GT * TICK;
   logic CLOCK = 1'b0;
   logic RST_N = 1'b0;
   logic RTT_ARM = 1'b0;
   logic RTT_CLEAR = 1'b0;
   logic UDC_CLEAR = 1'b0;
   prc_rtt_cfg_type RTT_CFG = '0;
   logic [26:0] UDC_PRESET = 27'h0000000;
   logic RTT_Q, RTT_BUSY, UDC_Q;
   logic [31:0] RTT_VALUE, RTT_RATE, UDC_VALUE;
   logic [2:0] go = 3'h0;
   logic [2:0][7:0] nt = '0;
   logic [2:0] lvl = 3'h0;
   wire [2:0] pins;
   int errors = 0;
   int n_checks = 0;
   logic [31:0] rng = 32'h0000001b;

   // ----------------------------------------------------------------
   // Clock, design and pin sources
   // ----------------------------------------------------------------
   always #25 CLOCK = ~CLOCK;

   prc_top #(.TICK_CYCLES(TICK)) prc_top_inst (
      .CLOCK(CLOCK), .RST_N(RST_N), .RTT_ARM(RTT_ARM),
      .PULSE_IN(pins[0]), .RTT_CLEAR(RTT_CLEAR), .RTT_CFG(RTT_CFG),
      .RTT_Q(RTT_Q), .RTT_BUSY(RTT_BUSY), .RTT_VALUE(RTT_VALUE),
      .RTT_RATE(RTT_RATE), .UP_IN(pins[1]), .DOWN_IN(pins[2]),
      .UDC_CLEAR(UDC_CLEAR), .UDC_PRESET(UDC_PRESET), .UDC_Q(UDC_Q),
      .UDC_VALUE(UDC_VALUE)
   );

   // Three sources, well under eight fast counting blocks
   prc_pin_src prc_pin_src_inst [2:0] (
      .clk(CLOCK), .rst_n(RST_N), .go(go), .n(nt), .pin(pins), .busy()
   );

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction : rnd

   // Counted edges of n toggles starting from level s
   function automatic logic [31:0] edges(input logic s,
                                         input logic [7:0] n,
                                         input logic fall);
      logic [31:0] rises;
      rises = s ? 32'(n / 2) : 32'((n + 8'h01) / 2);
      return fall ? 32'(n) - rises : rises;
   endfunction : edges

   // Expected switching output from rate and thresholds
   function automatic logic qf(input logic q, input logic [31:0] r,
                               input logic [26:0] on,
                               input logic [29:0] off);
      if (32'(on) >= 32'(off)) begin
         return (r >= 32'(on)) ? 1'b1 : ((r < 32'(off)) ? 1'b0 : q);
      end
      return (r >= 32'(on)) && (r < 32'(off));
   endfunction : qf

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic tick(input int k);
      repeat (k) @(posedge CLOCK);
   endtask : tick

   task automatic fire(input int w, input logic [7:0] n);
      nt[w] <= n;
      go[w] <= 1'b1;
      tick(1);
      go[w] <= 1'b0;
      lvl[w] = lvl[w] ^ n[0];
   endtask : fire

   task automatic wrap_up();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : wrap_up

   task automatic wait_busy();
      int k;
      for (k = 0; k < 20; k++) begin
         tick(1);
         #1;
         if (RTT_BUSY === 1'b1) break;
      end
      chk({31'h0, RTT_BUSY}, 32'h1);
      if (k == 20) wrap_up();
   endtask : wait_busy

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      int i, w;
      logic [31:0] v, r, e;
      logic [7:0] n;
      logic [26:0] p, on;
      logic [29:0] off;
      logic q;
      tick(10);
      RST_N <= 1'b1;
      tick(2);
      // Random up and down bursts with moving preset
      v = 32'h0;
      for (i = 0; i < 12; i++) begin
         n = 8'(rnd() % 9 + 1);
         w = int'(rnd() % 2) + 1;
         p = 27'(rnd() % 12);
         e = edges(lvl[w], n, 1'b0);
         v = (w == 1) ? v + e : ((v > e) ? v - e : 32'h0);
         UDC_PRESET <= p;
         fire(w, n);
         tick(2 * n + 8);
         #1 chk(UDC_VALUE, v);
         chk({31'h0, UDC_Q}, {31'h0, v >= 32'(p)});
         // Back onto a rising edge before driving again
         tick(1);
      end
      // Clear held while up pulses arrive
      UDC_PRESET <= 27'h0000005;
      UDC_CLEAR <= 1'b1;
      fire(1, 8'h09);
      tick(26);
      #1 chk(UDC_VALUE, 32'h0);
      chk({31'h0, UDC_Q}, 32'h0);
      tick(1);
      UDC_CLEAR <= 1'b0;
      // Down at zero stays at zero, preset zero is reached
      UDC_PRESET <= 27'h0000000;
      fire(2, 8'h04);
      tick(16);
      #1 chk(UDC_VALUE, 32'h0);
      chk({31'h0, UDC_Q}, 32'h1);
      tick(1);
      // Gated rate measurement, both counting modes
      RTT_CFG.gate_ticks <= 29'(GT);
      RTT_ARM <= 1'b1;
      wait_busy();
      tick(3);
      // All-zero thresholds with rate zero set the output after reset
      q = qf(1'b0, 32'h0, 27'h0, 30'h0);
      r = 32'h0;
      for (i = 0; i < 8; i++) begin
         n = 8'(rnd() % 40 + 1);
         on = 27'(rnd() % 24);
         off = 30'(rnd() % 24);
         RTT_CFG.falling <= (i >= 4);
         RTT_CFG.on_thr <= on;
         RTT_CFG.off_thr <= off;
         q = qf(q, r, on, off);
         e = edges(lvl[0], n, i >= 4);
         fire(0, n);
         tick(96);
         #1 chk(RTT_VALUE, e);
         tick(P - 98);
         #1 chk(RTT_RATE, e);
         r = e;
         q = qf(q, r, on, off);
         chk({31'h0, RTT_Q}, {31'h0, q});
         // Keeps each pass exactly one gate long, on an edge
         tick(1);
      end
      // Clear during pulses wins and stops the gate
      RTT_CLEAR <= 1'b1;
      fire(0, 8'h06);
      tick(16);
      #1 chk(RTT_VALUE, 32'h0);
      chk(RTT_RATE, 32'h0);
      chk({30'h0, RTT_Q, RTT_BUSY}, 32'h0);
      tick(1);
      RTT_CLEAR <= 1'b0;
      // Falling arm edge starts a new measurement
      RTT_ARM <= 1'b0;
      wait_busy();
      wrap_up();
   end
endmodule : test_prc_top
`default_nettype wire
